// [dv/ols_partner.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// trigger source on the far side of the pin
// ----------------------------------------------------------------
module ols_partner (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic fire,
  output logic      trig_in
);
  logic [1:0] hold_q;
  // three high cycles so the two-stage synchroniser cannot miss the edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_q  <= 2'h0;
      trig_in <= 1'b0;
    end else if (fire) begin
      hold_q  <= 2'h2;
      trig_in <= 1'b1;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      trig_in <= 1'b0;
    end
  end
endmodule

// [dv/test_output_list_sequencer.sv]
`timescale 1ns/1ns
module test_output_list_sequencer;
  typedef struct {logic [15:0] sp; logic [3:0] idx; int gap;} ols_exp_t;
  logic                        mclk = 1'b0, rst = 1'b1, fire = 1'b0;
  ols_pkg::ols_wr_t            list_wr = '0;
  logic [4:0]                  setpoint_len = 5'h00;
  logic                        dwell_single = 1'b0, cnt_wr = 1'b0, term_last = 1'b1;
  logic [15:0]                 cnt = 16'h0001, static_sp = 16'h0000, setpoint_out;
  ols_pkg::ols_pace_t          pace = ols_pkg::OLS_PACE_DWELL;
  logic                        mode = 1'b0, initiate = 1'b0, abort = 1'b0, trig_in;
  logic                        trig_out, list_done, running, armed;
  logic [3:0]                  step_idx;
  logic [15:0]                 repeat_count;
  int                          fail_count = 0, cmp_count = 0, gap = 0, dones = 0;
  logic [15:0]                 sp [16];
  int                          dw [16];
  ols_exp_t                    q [$];
  ols_exp_t                    e;

  ols_sequencer i_dut (.mclk(mclk), .rst(rst), .list_wr(list_wr),
    .setpoint_len(setpoint_len), .dwell_single(dwell_single),
    .repeat_count_wdata(cnt), .repeat_count_wr(cnt_wr), .term_last(term_last),
    .pace(pace), .function_transient_mode(mode), .static_setpoint(static_sp),
    .initiate(initiate), .abort(abort), .trig_in(trig_in),
    .setpoint_out(setpoint_out), .trig_out(trig_out), .list_done(list_done),
    .running(running), .armed(armed), .step_idx(step_idx),
    .repeat_count(repeat_count));
  ols_partner i_far (.mclk(mclk), .rst(rst), .fire(fire), .trig_in(trig_in));

  initial forever #2 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor: each trigger pulse consumes the oldest expectation
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    gap <= gap + 1;
    if (list_done === 1'b1) dones <= dones + 1;
    if (trig_out === 1'b1) begin
      gap <= 1;
      if (q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        e = q.pop_front();
        check(setpoint_out, e.sp);
        check(step_idx, e.idx);
        if (e.gap > 0) check(gap, e.gap);
      end
    end
  end

  task automatic prog(input int n, input logic [15:0] bf, ef, input int dmin, dmax);
    for (int i = 0; i < n; i++) begin
      sp[i] = 16'($urandom);
      dw[i] = $urandom_range(dmax, dmin);
      @(posedge mclk);
      list_wr <= '{1'b1, 4'(i), '{sp[i], 24'(dw[i]), bf[i], ef[i]}};
    end
    @(posedge mclk);
    list_wr.wr <= 1'b0;
    setpoint_len <= 5'(n);
  endtask

  task automatic run(input logic [15:0] count);
    @(posedge mclk);
    cnt <= count;
    cnt_wr <= 1'b1;
    @(posedge mclk);
    cnt_wr <= 1'b0;
    initiate <= 1'b1;
    @(posedge mclk);
    initiate <= 1'b0;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask

  task automatic expect_pass(input int n);
    for (int i = 0; i < n; i++) begin
      q.push_back('{sp[i], 4'(i), (i == 0) ? 0 : (dwell_single ? dw[0] : dw[i-1]) + 1});
    end
  endtask

  task automatic settle(input int want);
    for (int k = 0; k < 3000 && dones != want; k++) @(posedge mclk);
    repeat (8) @(posedge mclk);
    check(q.size(), 0);
    check(dones, want);
  endtask

  task automatic drain();
    for (int k = 0; k < 3000 && q.size() > 0; k++) @(posedge mclk);
  endtask

  // spaced so the partner's pin has fallen before the next rising edge
  task automatic pulse_fire();
    repeat (8) @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
  endtask

  initial begin
    void'($urandom(66303));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check(repeat_count, 16'h0001);
    prog(3, 16'hFFFF, 16'h0000, 0, 3);
    run(16'h0001);
    repeat (12) @(posedge mclk);
    check(armed, 1'b0);
    mode <= 1'b1;
    dwell_single <= 1'b1;
    prog(4, 16'hFFFF, 16'h0000, 0, 5);
    expect_pass(4);
    expect_pass(4);
    run(16'h0002);
    settle(1);
    check(setpoint_out, sp[3]);
    dwell_single <= 1'b0;
    term_last <= 1'b0;
    static_sp <= 16'($urandom);
    prog(5, 16'h0001, 16'h0004, 0, 5);
    q.push_back('{sp[0], 4'h0, 0});
    q.push_back('{sp[3], 4'h3, dw[0] + dw[1] + dw[2] + 3});
    run(16'h0001);
    settle(2);
    check(setpoint_out, static_sp);
    pace <= ols_pkg::OLS_PACE_TRIG;
    prog(3, 16'hFFFF, 16'h0000, 30, 30);
    q.push_back('{sp[0], 4'h0, 0});
    run(16'h0001);
    drain();
    repeat (8) @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (40) @(posedge mclk);
    q.push_back('{sp[1], 4'h1, 0});
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    drain();
    repeat (20) @(posedge mclk);
    check(step_idx, 4'h1);
    abort <= 1'b1;
    @(posedge mclk);
    abort <= 1'b0;
    pace <= ols_pkg::OLS_PACE_DWELL;
    prog(2, 16'hFFFF, 16'h0000, 10, 12);
    repeat (3) expect_pass(2);
    run(ols_pkg::COUNT_INF);
    drain();
    abort <= 1'b1;
    @(posedge mclk);
    abort <= 1'b0;
    repeat (4) @(posedge mclk);
    check(running, 1'b0);
    check(dones, 2);
    pace <= ols_pkg::OLS_PACE_TRIG;
    prog(2, 16'hFFFF, 16'h0000, 0, 0);
    q.push_back('{sp[0], 4'h0, 0});
    q.push_back('{sp[1], 4'h1, 0});
    run(16'h0001);
    repeat (2) pulse_fire();
    settle(3);
    check(setpoint_out, static_sp);
    pace <= ols_pkg::OLS_PACE_DWELL;
    term_last <= ols_pkg::TERM_HOLD;
    cnt <= 16'h0005;
    cnt_wr <= 1'b1;
    @(posedge mclk);
    cnt_wr <= 1'b0;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check(repeat_count, 16'h0001);
    run(16'h0001);
    settle(4);
    check(setpoint_out, 16'h0000);
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    end_of_test();
  end
endmodule

// [verilog/ols_pkg.sv]
package ols_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH      = 16;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned LEN_W      = 5;
  localparam int unsigned SET_W      = 16;
  localparam int unsigned DWELL_W    = 24;
  localparam int unsigned COUNT_W    = 16;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_INF   = 16'h0000;
  localparam logic               TERM_RETURN = 1'b0;
  localparam logic               TERM_HOLD   = 1'b1;
  localparam logic [IDX_W-1:0]   IDX_FIRST   = 4'h0;

  typedef enum logic [1:0] {
    OLS_FN_VOLT,
    OLS_FN_CURR,
    OLS_FN_POW,
    OLS_FN_RES
  } ols_func_t;

  typedef enum logic {
    OLS_PACE_DWELL,
    OLS_PACE_TRIG
  } ols_pace_t;

  // one programmed list entry
  typedef struct packed {
    logic [SET_W-1:0]   setpoint;
    logic [DWELL_W-1:0] dwell;
    logic               begin_step_trigger_flag;
    logic               end_step_trigger_flag;
  } ols_entry_t;

  // write port into the list storage
  typedef struct packed {
    logic               wr;
    logic [IDX_W-1:0]   idx;
    ols_entry_t         entry;
  } ols_wr_t;

endpackage

// [verilog/ols_sequencer.sv]
`timescale 1ns/1ns
module ols_sequencer (
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire ols_pkg::ols_wr_t                 list_wr,
  input  wire logic [ols_pkg::LEN_W-1:0]        setpoint_len,
  input  wire logic                             dwell_single,
  input  wire logic [ols_pkg::COUNT_W-1:0]      repeat_count_wdata,
  input  wire logic                             repeat_count_wr,
  input  wire logic                             term_last,
  input  wire ols_pkg::ols_pace_t               pace,
  input  wire logic                             function_transient_mode,
  input  wire logic [ols_pkg::SET_W-1:0]        static_setpoint,
  input  wire logic                             initiate,
  input  wire logic                             abort,
  input  wire logic                             trig_in,
  output logic [ols_pkg::SET_W-1:0]             setpoint_out,
  output logic                                  trig_out,
  output logic                                  list_done,
  output logic                                  running,
  output logic                                  armed,
  output logic [ols_pkg::IDX_W-1:0]             step_idx,
  output logic [ols_pkg::COUNT_W-1:0]           repeat_count
);

  // ----------------------------------------------------------------
  // pin synchroniser and trigger edge
  // ----------------------------------------------------------------
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  logic trig_pulse;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_pulse = trig_s2_q & ~trig_s3_q;

  // ----------------------------------------------------------------
  // list storage
  // ----------------------------------------------------------------
  ols_pkg::ols_entry_t mem_q [ols_pkg::DEPTH];

  // storage clears on reset, nothing survives a power cycle
  generate
    for (genvar g = 0; g < ols_pkg::DEPTH; g++) begin : g_mem
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          mem_q[g] <= '0;
        end else if (list_wr.wr && list_wr.idx == ols_pkg::IDX_W'(g)) begin
          mem_q[g] <= list_wr.entry;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // repeat count register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      repeat_count <= ols_pkg::COUNT_RESET;
    end else if (repeat_count_wr) begin
      repeat_count <= repeat_count_wdata;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OLS_IDLE,
    OLS_ARMED,
    OLS_DWELL,
    OLS_WAIT
  } ols_state_t;

  ols_state_t                    state_q;
  logic [ols_pkg::DWELL_W-1:0]   dwell_q;
  logic [ols_pkg::COUNT_W-1:0]   pass_q;
  logic [ols_pkg::SET_W-1:0]     saved_q;
  logic [ols_pkg::IDX_W-1:0]     last_idx;
  logic [ols_pkg::IDX_W-1:0]     nxt_idx;
  logic [ols_pkg::DWELL_W-1:0]   cur_dwell;
  ols_pkg::ols_entry_t           cur;
  ols_pkg::ols_entry_t           nxt;
  logic                          dwell_done;
  logic                          advance;
  logic                          last_entry;
  logic                          last_pass;

  function automatic logic [ols_pkg::DWELL_W-1:0] dwell_of(input logic [ols_pkg::IDX_W-1:0] i);
    dwell_of = dwell_single ? mem_q[0].dwell : mem_q[i].dwell;
  endfunction

  assign last_idx   = ols_pkg::IDX_W'(setpoint_len - 1'b1);
  assign cur        = mem_q[step_idx];
  // one wrap decode shared by the fetch, the index update and the dwell load
  assign nxt_idx    = last_entry ? ols_pkg::IDX_FIRST : step_idx + 1'b1;
  assign nxt        = mem_q[nxt_idx];
  assign cur_dwell  = dwell_of(step_idx);
  assign dwell_done = (dwell_q == '0);
  assign last_entry = (step_idx == last_idx);
  assign last_pass  = (repeat_count != ols_pkg::COUNT_INF) && (pass_q >= repeat_count - 1'b1);
  // trigger while dwell runs is simply not seen here
  assign advance    = (state_q == OLS_DWELL && dwell_done && pace == ols_pkg::OLS_PACE_DWELL)
                   || (state_q == OLS_WAIT && trig_pulse);
  assign running    = (state_q == OLS_DWELL) || (state_q == OLS_WAIT);
  assign armed      = (state_q == OLS_ARMED);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q  <= OLS_IDLE;
      step_idx <= ols_pkg::IDX_FIRST;
      dwell_q  <= '0;
      pass_q   <= '0;
    end else if (abort || !function_transient_mode) begin
      state_q <= OLS_IDLE;
    end else begin
      case (state_q)
        OLS_IDLE: begin
          if (initiate && setpoint_len != '0) begin
            state_q <= OLS_ARMED;
          end
        end
        OLS_ARMED: begin
          if (trig_pulse) begin
            state_q  <= OLS_DWELL;
            step_idx <= ols_pkg::IDX_FIRST;
            dwell_q  <= dwell_of(ols_pkg::IDX_FIRST);
            pass_q   <= '0;
          end
        end
        OLS_DWELL: begin
          if (!dwell_done) begin
            dwell_q <= dwell_q - 1'b1;
          end else if (pace == ols_pkg::OLS_PACE_TRIG) begin
            state_q <= OLS_WAIT;
          end
        end
        OLS_WAIT: begin
        end
        default: state_q <= OLS_IDLE;
      endcase
      if (advance) begin
        if (last_entry && last_pass) begin
          state_q <= OLS_IDLE;
        end else begin
          state_q  <= OLS_DWELL;
          step_idx <= nxt_idx;
          dwell_q  <= dwell_of(nxt_idx);
          if (last_entry) begin
            pass_q <= pass_q + 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic start_now;
  logic finish_now;

  assign start_now  = (state_q == OLS_ARMED) && trig_pulse && function_transient_mode && !abort;
  assign finish_now = advance && last_entry && last_pass && function_transient_mode && !abort;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      saved_q      <= '0;
      setpoint_out <= '0;
    end else if (start_now) begin
      saved_q      <= static_setpoint;
      setpoint_out <= mem_q[0].setpoint;
    end else if (finish_now) begin
      setpoint_out <= (term_last == ols_pkg::TERM_HOLD) ? cur.setpoint : saved_q;
    end else if (advance && function_transient_mode && !abort) begin
      setpoint_out <= nxt.setpoint;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_out  <= 1'b0;
      list_done <= 1'b0;
    end else begin
      // end flag of the leaving entry and begin flag of the arriving one share a pulse
      trig_out <= (start_now && mem_q[0].begin_step_trigger_flag)
               || (advance && function_transient_mode && !abort
                   && (cur.end_step_trigger_flag
                       || (!finish_now && nxt.begin_step_trigger_flag)));
      list_done <= finish_now;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_COUNT: assert property (@(posedge mclk) $fell(rst) |-> repeat_count == ols_pkg::COUNT_RESET)
    else $error("repeat count not one after reset");
  AST_DWELL_ADV: assert property (@(posedge mclk) disable iff (rst)
    state_q == OLS_DWELL && dwell_done && pace == ols_pkg::OLS_PACE_DWELL && !last_entry
    && function_transient_mode && !abort |=> step_idx == $past(step_idx) + 1'b1)
    else $error("dwell paced step did not advance when dwell expired");
  AST_NO_EARLY_TRIG: assert property (@(posedge mclk) disable iff (rst)
    state_q == OLS_DWELL && !dwell_done && pace == ols_pkg::OLS_PACE_TRIG
    |=> $stable(step_idx))
    else $error("trigger paced step moved during dwell");
  AST_TRIG_STEP: assert property (@(posedge mclk) disable iff (rst)
    state_q == OLS_WAIT && trig_pulse && !last_entry && function_transient_mode && !abort
    |=> step_idx == $past(step_idx) + 1'b1)
    else $error("trigger did not advance one entry");
  AST_DONE_IDLE: assert property (@(posedge mclk) disable iff (rst)
    list_done |-> state_q == OLS_IDLE)
    else $error("done while still running");
  AST_MODE_OFF: assert property (@(posedge mclk) disable iff (rst)
    !function_transient_mode |=> !running)
    else $error("sequencing with mode not list");
  AST_ARM_FIRST: assert property (@(posedge mclk) disable iff (rst)
    $rose(running) |-> $past(state_q) == OLS_ARMED)
    else $error("list started without initiate");
  AST_START_IDX: assert property (@(posedge mclk) disable iff (rst)
    start_now |=> step_idx == ols_pkg::IDX_FIRST && setpoint_out == $past(mem_q[0].setpoint))
    else $error("list did not start at entry zero");
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    finish_now && term_last |=> setpoint_out == $past(cur.setpoint))
    else $error("hold last setpoint lost");

endmodule
